// >>> logic/dfr_consts.svh
`ifndef DFR_CONSTS_SVH
`define DFR_CONSTS_SVH

// Register byte offsets
`define DFR_ADDR_CTRL 4'h0
`define DFR_ADDR_STAT 4'h4
`define DFR_ADDR_REF 4'h8

// Control register fields
`define DFR_CTRL_FMT_LSB 0
`define DFR_CTRL_SRC_LSB 4

// Status register fields
`define DFR_STAT_GOOD 0
`define DFR_STAT_NEG 1
`define DFR_STAT_MAX 2
`define DFR_STAT_ERR 3
`define DFR_STAT_WIDE 4
`define DFR_STAT_W16 5
`define DFR_STAT_ACT 6

// Reset values
`define DFR_RST_FMT 3'h0
`define DFR_RST_SRC 3'h0

// Reference source code that selects the option card
`define DFR_SRC_OPTION 3'h3

`endif

// >>> logic/dfr_pkg.sv
package dfr_pkg;

    // Input format selection codes
    typedef enum logic [2:0] {
        FMT_BCD_1PCT = 3'h0,
        FMT_BCD_01PCT = 3'h1,
        FMT_BCD_001PCT = 3'h2,
        FMT_BCD_1HZ = 3'h3,
        FMT_BCD_01HZ = 3'h4,
        FMT_BCD_001HZ = 3'h5,
        FMT_BCD5_001HZ = 3'h6,
        FMT_BINARY = 3'h7
    } fmt_e;

    // Whole state of the decoder
    typedef struct packed {
        logic [2:0] fmt;
        logic [2:0] src;
        logic [16:0] mag;
        logic neg;
        logic max;
        logic good;
        logic act;
        logic err;
        logic [31:0] rdata;
    } dfr_state_s;

endpackage

// >>> logic/bcd_digits.sv
`timescale 1ns/1ps

module bcd_digits
    import dfr_pkg::*;
#(
    parameter int NDIG = 5,
    parameter int VAL_W = 17
) (
    // Packed digits, digit 1 in the low nibble
    input wire logic [4*NDIG-1:0] digits,
    // Digits allowed to run past nine
    input wire logic [NDIG-1:0] free_mask,
    // Result
    output logic [VAL_W-1:0] value,
    output logic bad
);

    if (NDIG < 1 || VAL_W < 4) begin : g_chk
        $error("bcd_digits: unsupported size");
    end

    logic [NDIG-1:0] over;

    // Flag each digit outside free_mask that is not a decimal digit
    for (genvar i = 0; i < NDIG; i++) begin : g_dig
        assign over[i] = (digits[4*i+:4] > 4'h9) && !free_mask[i];
    end

    assign bad = |over;

    // Horner accumulation from the top digit down
    always_comb begin
        value = '0;
        for (int i = NDIG - 1; i >= 0; i--) begin
            value = VAL_W'(value * VAL_W'(10)) + VAL_W'(digits[4*i+:4]);
        end
    end

endmodule // bcd_digits

// >>> logic/digital_freq_reference_decoder.sv
// Overview of operation
// RULE_01: Wide card decode uses format and width switch
// RULE_02: Narrow binary: terminal 1..8 weigh 2^0..2^7
// RULE_03: Binary formats all ones mean full speed
// RULE_04: Format 6 valid only on wide card
// RULE_05: Format 6 spans 0.00 to 399.98 Hz
// RULE_06: Format 6 uses sign as data, positive
// RULE_07: Format 6 lowest nonzero value is 0.02 Hz
// RULE_08: Narrow card decode uses format selection only
// RULE_09: Narrow card with format 6 yields nothing
// RULE_10: Format codes 0-5 BCD, 6 five-digit, 7 binary
// RULE_11: Card reference used only when source is 3
// RULE_12: Sign low forward, high reverse
// RULE_13: Terminals captured only while strobe high
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "dfr_consts.svh"

module digital_freq_reference_decoder
    import dfr_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int NARROW_W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Card straps
    input wire logic card_wide,
    input wire logic word_width_switch,
    // Reference terminals
    input wire logic [DATA_W-1:0] data_terminals,
    input wire logic sign_terminal,
    input wire logic read_strobe,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Decoded reference
    output logic [16:0] ref_mag,
    output logic ref_neg,
    output logic ref_max,
    output logic ref_good,
    output logic ref_active,
    output logic ref_err
);

    if (DATA_W != 16 || NARROW_W != 8) begin : g_chk
        $error("digital_freq_reference_decoder: only 16/8 bit terminals supported");
    end

    dfr_state_s s_q;
    dfr_state_s s_d;

    logic [19:0] bcd_in;
    logic [4:0] bcd_free;
    logic [16:0] bcd_val;
    logic bcd_bad;
    logic is_bin;
    logic is_five;
    logic [16:0] bin_val;
    logic bin_ones;

    // Format decode from the current selection
    assign is_bin = (s_q.fmt == FMT_BINARY); // [RULE_10]
    assign is_five = (s_q.fmt == FMT_BCD5_001HZ); // [RULE_10]

    // Digit layout per card, width and format
    always_comb begin
        bcd_free = 5'h00;
        if (is_five) begin
            // Digit 1 has an implicit zero bit, sign is the top digit's bit
            bcd_in = {2'b00, sign_terminal, data_terminals, 1'b0}; // [RULE_05] [RULE_06] [RULE_07]
        end else if (card_wide && word_width_switch) begin
            bcd_in = {4'h0, data_terminals}; // [RULE_01]
        end else if (card_wide) begin
            bcd_in = {8'h00, data_terminals[11:0]}; // [RULE_01]
        end else begin
            bcd_in = {12'h000, data_terminals[7:0]}; // [RULE_08]
            bcd_free = 5'h02;
        end
    end

    // Binary value and all-ones detect per width
    always_comb begin
        if (is_five) begin
            bin_val = {sign_terminal, data_terminals};
            bin_ones = &{sign_terminal, data_terminals};
        end else if (card_wide && word_width_switch) begin
            bin_val = {1'b0, data_terminals}; // [RULE_01]
            bin_ones = &data_terminals;
        end else if (card_wide) begin
            bin_val = {5'h00, data_terminals[11:0]}; // [RULE_01]
            bin_ones = &data_terminals[11:0];
        end else begin
            bin_val = {9'h000, data_terminals[7:0]}; // [RULE_02]
            bin_ones = &data_terminals[7:0];
        end
    end

    bcd_digits #(
        .NDIG(5),
        .VAL_W(17)
    ) bcd_digits_inst (
        .digits(bcd_in),
        .free_mask(bcd_free),
        .value(bcd_val),
        .bad(bcd_bad)
    );

    // Next state: register writes, capture, read data
    always_comb begin
        s_d = s_q;
        s_d.rdata = 32'h0000_0000;
        if (reg_wr) begin
            if (reg_addr == `DFR_ADDR_CTRL) begin
                s_d.fmt = reg_wdata[`DFR_CTRL_FMT_LSB+:3];
                s_d.src = reg_wdata[`DFR_CTRL_SRC_LSB+:3];
            end
        end
        if (read_strobe) begin // [RULE_13]
            s_d.err = is_five && !card_wide; // [RULE_04] [RULE_09]
            s_d.good = !s_d.err && (is_bin || !bcd_bad);
            s_d.neg = is_five ? 1'b0 : sign_terminal; // [RULE_06] [RULE_12]
            s_d.max = (is_bin || (is_five && card_wide)) && bin_ones; // [RULE_03]
            if (is_bin) begin
                s_d.mag = bin_val;
            end else begin
                s_d.mag = bcd_val;
            end
        end
        s_d.act = s_d.good && (s_d.src == `DFR_SRC_OPTION); // [RULE_11]
        if (reg_rd) begin
            if (reg_addr == `DFR_ADDR_CTRL) begin
                s_d.rdata = {25'h0, s_q.src, 1'b0, s_q.fmt};
            end else if (reg_addr == `DFR_ADDR_STAT) begin
                s_d.rdata = {25'h0, s_q.act, word_width_switch, card_wide,
                             s_q.err, s_q.max, s_q.neg, s_q.good};
            end else if (reg_addr == `DFR_ADDR_REF) begin
                s_d.rdata = {15'h0, s_q.mag};
            end else begin
                s_d.rdata = 32'h0000_0000;
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= '{fmt: `DFR_RST_FMT, src: `DFR_RST_SRC, mag: 17'h00000, neg: 1'b0,
                     max: 1'b0, good: 1'b0, act: 1'b0, err: 1'b0, rdata: 32'h0000_0000};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata = s_q.rdata;
    assign ref_mag = s_q.mag;
    assign ref_neg = s_q.neg;
    assign ref_max = s_q.max;
    assign ref_good = s_q.good;
    assign ref_active = s_q.act;
    assign ref_err = s_q.err;

    // Checks on the decoded reference
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_hold_no_strobe;
        !read_strobe |=> $stable(ref_mag) && $stable(ref_neg) && $stable(ref_good);
    endproperty
    a_hold_no_strobe: assert property (p_hold_no_strobe) // [RULE_13]
        else $error("reference changed without strobe");

    property p_act_src;
        ref_active |-> (s_q.src == `DFR_SRC_OPTION) && ref_good;
    endproperty
    a_act_src: assert property (p_act_src) // [RULE_11]
        else $error("active without option source");

    property p_narrow_five;
        read_strobe && !card_wide && is_five |=> !ref_good && ref_err && !ref_active;
    endproperty
    a_narrow_five: assert property (p_narrow_five) // [RULE_09]
        else $error("narrow card format 6 produced a reference");

    property p_five_pos;
        read_strobe && is_five |=> !ref_neg;
    endproperty
    a_five_pos: assert property (p_five_pos) // [RULE_06]
        else $error("format 6 gave negative reference");

    property p_bin_max;
        read_strobe && is_bin && card_wide && word_width_switch && (&data_terminals)
            |=> ref_max && (ref_mag == 17'h0ffff);
    endproperty
    a_bin_max: assert property (p_bin_max) // [RULE_03]
        else $error("binary all ones not full scale");

    property p_narrow_bin;
        read_strobe && !card_wide && is_bin
            |=> ref_mag == {9'h000, $past(data_terminals[7:0])};
    endproperty
    a_narrow_bin: assert property (p_narrow_bin) // [RULE_02]
        else $error("narrow binary weight wrong");

    property p_five_min;
        read_strobe && card_wide && is_five && !sign_terminal && data_terminals == 16'h0001
            |=> ref_good && ref_mag == 17'd2;
    endproperty
    a_five_min: assert property (p_five_min) // [RULE_07]
        else $error("format 6 lowest step not 0.02");

    property p_five_top;
        read_strobe && card_wide && is_five && sign_terminal && data_terminals == 16'hcccc
            |=> ref_good && ref_mag == 17'd39998;
    endproperty
    a_five_top: assert property (p_five_top) // [RULE_05]
        else $error("format 6 top value wrong");

    property p_sign;
        read_strobe && !is_five |=> ref_neg == $past(sign_terminal);
    endproperty
    a_sign: assert property (p_sign) // [RULE_12]
        else $error("sign not applied");

    property p_w12;
        read_strobe && card_wide && !word_width_switch && !is_bin && !is_five
            && data_terminals[11:0] == 12'h123 |=> ref_good && ref_mag == 17'd123;
    endproperty
    a_w12: assert property (p_w12) // [RULE_01]
        else $error("12-bit BCD decode wrong");

    property p_narrow_bcd;
        read_strobe && !card_wide && !is_bin && !is_five && data_terminals[7:0] == 8'hf9
            |=> ref_good && ref_mag == 17'd159;
    endproperty
    a_narrow_bcd: assert property (p_narrow_bcd) // [RULE_08]
        else $error("narrow BCD decode wrong");

    c_active: cover property (read_strobe ##1 ref_active);
    c_five: cover property (read_strobe && is_five && card_wide ##1 ref_good);
    c_bin_max: cover property (read_strobe && is_bin ##1 ref_max);

endmodule // digital_freq_reference_decoder

// >>> testbench/ref_controller.sv
`timescale 1ns/1ps

module ref_controller (
    // Clock
    input wire logic mclk,
    // Terminals toward the card
    output logic [15:0] data_terminals,
    output logic sign_terminal,
    output logic read_strobe
);
    // Idle lines at time zero
    initial begin
        data_terminals = 16'h0000;
        sign_terminal = 1'b0;
        read_strobe = 1'b0;
    end

    // Strobe one word, then scramble the lines so stale data is never reused
    task automatic send(input logic [15:0] d, input logic s);
        @(posedge mclk);
        data_terminals <= d;
        sign_terminal <= s;
        read_strobe <= 1'b1;
        @(posedge mclk);
        read_strobe <= 1'b0;
        data_terminals <= ~d;
        sign_terminal <= ~s;
    endtask
endmodule // ref_controller

// >>> testbench/digital_freq_reference_decoder_tb.sv
`timescale 1ns/1ps
`include "dfr_consts.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module digital_freq_reference_decoder_tb
    import dfr_pkg::*;
;
    logic mclk;
    logic rst_n;
    logic card_wide;
    logic word_width_switch;
    logic [15:0] data_terminals;
    logic sign_terminal;
    logic read_strobe;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [16:0] ref_mag;
    logic ref_neg, ref_max, ref_good, ref_active, ref_err;
    logic [31:0] v;
    int n_mismatch = 0;
    int n_compared = 0;

    digital_freq_reference_decoder #(.DATA_W(16), .NARROW_W(8)) digital_freq_reference_decoder_inst (
        .mclk(mclk), .rst_n(rst_n), .card_wide(card_wide), .word_width_switch(word_width_switch),
        .data_terminals(data_terminals), .sign_terminal(sign_terminal),
        .read_strobe(read_strobe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_mag(ref_mag),
        .ref_neg(ref_neg), .ref_max(ref_max), .ref_good(ref_good),
        .ref_active(ref_active), .ref_err(ref_err));

    ref_controller ref_controller_inst (.mclk(mclk), .data_terminals(data_terminals),
        .sign_terminal(sign_terminal), .read_strobe(read_strobe));

    // Register write and read cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Straps plus format and source setup
    task automatic setf(input logic w, input logic s, input logic [2:0] f, input logic [2:0] src);
        @(posedge mclk);
        card_wide <= w;
        word_width_switch <= s;
        wr(`DFR_ADDR_CTRL, {25'h0, src, 1'b0, f});
    endtask

    // One capture; flags are {neg, max, good, err}
    task automatic take(input logic [15:0] d, input logic s, input logic [16:0] m,
        input logic [3:0] f);
        ref_controller_inst.send(d, s);
        #1;
        `CHK(ref_mag, m);
        `CHK({ref_neg, ref_max, ref_good, ref_err}, f);
    endtask

    task automatic t_regs;
        rd(`DFR_ADDR_CTRL);
        `CHK(v, 32'h0000_0000);
        wr(`DFR_ADDR_CTRL, 32'h0000_0037);
        wr(`DFR_ADDR_STAT, 32'hffff_ffff);
        rd(`DFR_ADDR_CTRL);
        `CHK(v, 32'h0000_0037);
        rd(4'hc);
        `CHK(v, 32'h0000_0000);
    endtask

    task automatic t_binary;
        setf(1'b0, 1'b1, FMT_BINARY, 3'h3);
        take(16'h00ff, 1'b1, 17'h000ff, 4'b1110);
        `CHK(ref_active, 1'b1);
        rd(`DFR_ADDR_STAT);
        `CHK(v, 32'h0000_0067);
        take(16'hff81, 1'b0, 17'h00081, 4'b0010);
        setf(1'b1, 1'b0, FMT_BINARY, 3'h3);
        take(16'hafff, 1'b0, 17'h00fff, 4'b0110);
        setf(1'b1, 1'b1, FMT_BINARY, 3'h3);
        take(16'hffff, 1'b1, 17'h0ffff, 4'b1110);
        take(16'h1234, 1'b0, 17'h01234, 4'b0010);
    endtask

    task automatic t_bcd;
        for (int f = 0; f < 6; f++) begin
            setf(1'b1, 1'b0, 3'(f), 3'h3);
            take(16'h9456, 1'b1, 17'd456, 4'b1010);
        end
        take(16'hf123, 1'b0, 17'd123, 4'b0010);
        setf(1'b1, 1'b1, FMT_BCD_001HZ, 3'h3);
        take(16'h9456, 1'b0, 17'd9456, 4'b0010);
        setf(1'b0, 1'b1, FMT_BCD_1HZ, 3'h3);
        take(16'h12f9, 1'b1, 17'd159, 4'b1010);
    endtask

    task automatic t_five;
        setf(1'b1, 1'b1, FMT_BCD5_001HZ, 3'h3);
        take(16'h0001, 1'b0, 17'd2, 4'b0010);
        take(16'hcccc, 1'b1, 17'd39998, 4'b0010);
        setf(1'b0, 1'b1, FMT_BCD5_001HZ, 3'h3);
        ref_controller_inst.send(16'h0001, 1'b0);
        #1;
        `CHK({ref_good, ref_err, ref_active}, 3'b010);
    endtask

    // Lines change with strobe low, then source moves away from the card
    task automatic t_hold;
        setf(1'b1, 1'b1, FMT_BINARY, 3'h3);
        take(16'h0321, 1'b0, 17'h00321, 4'b0010);
        repeat (3) @(posedge mclk);
        #1;
        `CHK(ref_mag, 17'h00321);
        wr(`DFR_ADDR_CTRL, 32'h0000_0007);
        repeat (2) @(posedge mclk);
        #1;
        `CHK(ref_active, 1'b0);
    endtask

    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        stop_test();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        card_wide = 1'b1;
        word_width_switch = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_binary();
        t_bcd();
        t_five();
        t_hold();
        stop_test();
    end
endmodule // digital_freq_reference_decoder_tb
